/* hw/rcf_pkg.sv */
package rcf_pkg;

  // Register map of the CPU bus
  localparam int unsigned    RCF_AW          = 16;
  localparam logic [15:0]    RCF_STATUS_ADDR = 16'h1800;
  localparam logic [15:0]    RCF_FORCE_ADDR  = 16'h1801;

  // Reset cause field positions
  localparam int unsigned    RCF_B_POR   = 7;
  localparam int unsigned    RCF_B_PIN   = 6;
  localparam int unsigned    RCF_B_WD    = 5;
  localparam int unsigned    RCF_B_ILLEGAL_OPCODE_FLAG  = 4;
  localparam int unsigned    RCF_B_ILLEGAL_ADDRESS_FLAG  = 3;
  localparam int unsigned    RCF_B_LOC   = 2;
  localparam int unsigned    RCF_B_LV    = 1;
  localparam int unsigned    RCF_B_FORCE = 0;

  // Values
  localparam logic [7:0]     RCF_POR_VALUE = 8'h82;
  localparam logic [7:0]     RCF_SVC_FIRST = 8'h55;
  localparam logic [7:0]     RCF_SVC_SECOND = 8'hAA;
  localparam logic [7:0]     RCF_READ_ZERO = 8'h00;

  // Timing of the internal reset pulse
  localparam int unsigned    RCF_CLK_NS   = 4;
  localparam int unsigned    RCF_HOLD_NS  = 32;
  localparam int unsigned    RCF_HOLD_CYC = (RCF_HOLD_NS + RCF_CLK_NS - 1) / RCF_CLK_NS;

  // Sequencer states
  typedef enum logic [1:0] {
    RCF_RUN  = 2'b01,
    RCF_HOLD = 2'b10
  } rcf_state_e;

endpackage

/* hw/rcf_reset_cause.sv */
// Contract
// R1 - The reset cause register holds read-only flags naming the source of the latest reset.
// R2 - A reset forced by the debug host leaves every reset cause flag clear.
// R3 - With the watchdog enabled, a write of any value but 0x55 or 0xAA to the cause address trips a watchdog reset.
// R4 - Writing 0x55 then 0xAA to the cause address clears the watchdog counter and keeps the flags.
// R5 - Power-on reset sets the power-on flag in bit 7 and the low-voltage flag in bit 1, clearing the rest.
// R6 - An enabled low-voltage trip resets and sets the low-voltage flag while the power-on flag keeps its value.
// R7 - Other resets set the flag of each source active at reset entry and clear the others, power-on and low-voltage 0.
// R8 - A low level on the external reset pin sets the pin flag in bit 6.
// R9 - A watchdog timeout sets the watchdog flag in bit 5, and the source is blocked while the watchdog is disabled.
// R10 - An unimplemented opcode, a stop while stop is barred, or background entry while barred sets bit 4.
// R11 - An access to an unimplemented address sets the illegal address flag in bit 3.
// R12 - Loss of the external clock sets the clock loss flag in bit 2.
// R13 - Writes to the force register from the user program are ignored; only serial debug writes act.
// R14 - Reads of the force register always return zero.
// R15 - A debug write of 1 to bit 0 of the force register forces a full device reset.
// R16 - In window mode any write to the cause address before the window opens causes a reset; the code resets only with the watchdog enabled.
// R17 - Only a 0xAA write right after a 0x55 write to the cause address counts as a service.
module rcf_reset_cause
  import rcf_pkg::*;
#(
  parameter int unsigned HOLD_CYC = RCF_HOLD_CYC
) (
  // Clock and reset
  input  logic              sys_clk,
  input  logic              rst,
  // CPU bus
  input  logic [RCF_AW-1:0] bus_addr,
  input  logic              bus_wr,
  input  logic              bus_rd,
  input  logic              bus_bdm,
  input  logic [7:0]        bus_wdata,
  output logic [7:0]        bus_rdata_q,
  // Configuration
  input  logic              watchdog_enable,
  input  logic              watchdog_window_mode,
  input  logic              watchdog_window_open,
  input  logic              low_voltage_reset_enable,
  input  logic              stop_allowed,
  input  logic              background_mode_allowed,
  // Reset sources
  input  logic              pin_reset_n,
  input  logic              watchdog_timeout,
  input  logic              lv_below_trip,
  input  logic              opcode_unimpl,
  input  logic              stop_exec,
  input  logic              background_entry_opcode,
  input  logic              illegal_access,
  input  logic              clock_lost,
  // Results
  output logic              sys_reset_q,
  output logic              watchdog_clear_q,
  output logic [7:0]        reset_cause_q
);

  localparam int unsigned CW = $clog2(HOLD_CYC + 1);

  function automatic logic addr_hit(input logic [RCF_AW-1:0] a, input logic [RCF_AW-1:0] off);
    return (a == off);
  endfunction

  rcf_state_e state_q;
  rcf_state_e state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [7:0]    cause_d;
  logic [7:0]    rdata_d;
  logic          in_run;
  logic          in_hold;
  logic          hit_st;
  logic          hit_force;
  logic          st_wr;
  logic          force_src;
  logic          trip_q;
  logic          pin_src;
  logic          wd_src;
  logic          illegal_opcode_flag_src;
  logic          lv_src;
  logic          any_src;
  logic          enter;
  logic          leave;
  logic [7:0]    src_vec;
  logic [7:0]    lv_vec;

  // Bus decode
  assign hit_st    = addr_hit(bus_addr, RCF_STATUS_ADDR);
  assign hit_force = addr_hit(bus_addr, RCF_FORCE_ADDR);
  assign st_wr     = bus_wr & hit_st & in_run;
  // User program writes lack the debug qualifier and fall away here
  assign force_src = bus_wr & hit_force & bus_bdm & bus_wdata[RCF_B_FORCE]; // R13 R15

  // Status reads show the flags; everything else reads zero
  assign rdata_d = (bus_rd & hit_st) ? reset_cause_q : RCF_READ_ZERO; // R1 R14

  assign in_run  = (state_q == RCF_RUN);
  assign in_hold = (state_q == RCF_HOLD);

  rcf_svc_seq u_svc (
    .sys_clk     (sys_clk),
    .rst         (rst),
    .clear       (in_hold),
    .wr          (st_wr),
    .wdata       (bus_wdata),
    .window_mode (watchdog_window_mode),
    .window_open (watchdog_window_open),
    .service_q   (watchdog_clear_q),
    .bad_q       (trip_q)
  );

  // Source qualification
  assign pin_src  = ~pin_reset_n; // R8
  assign wd_src   = watchdog_enable & (watchdog_timeout | trip_q); // R3 R9
  assign illegal_opcode_flag_src = opcode_unimpl | (stop_exec & ~stop_allowed)
                  | (background_entry_opcode & ~background_mode_allowed); // R10
  assign lv_src   = low_voltage_reset_enable & lv_below_trip; // R6
  assign any_src  = pin_src | wd_src | illegal_opcode_flag_src | illegal_access | clock_lost | lv_src | force_src;

  // Flags of the other sources, power-on and low-voltage forced low
  assign src_vec[RCF_B_POR]   = 1'b0; // R7
  assign src_vec[RCF_B_PIN]   = pin_src; // R8
  assign src_vec[RCF_B_WD]    = wd_src; // R9
  assign src_vec[RCF_B_ILLEGAL_OPCODE_FLAG]  = illegal_opcode_flag_src; // R10
  assign src_vec[RCF_B_ILLEGAL_ADDRESS_FLAG]  = illegal_access; // R11
  assign src_vec[RCF_B_LOC]   = clock_lost; // R12
  assign src_vec[RCF_B_LV]    = 1'b0; // R7
  assign src_vec[RCF_B_FORCE] = 1'b0;

  // Low-voltage pattern keeps the power-on flag as it was
  for (genvar i = 0; i < 8; i++) begin : g_lv
    if (i == RCF_B_POR) begin : g_keep
      assign lv_vec[i] = reset_cause_q[i]; // R6
    end else begin : g_fix
      assign lv_vec[i] = (i == RCF_B_LV); // R6
    end
  end

  // A debug force wins over everything so the host sees a clean register
  assign cause_d = force_src ? 8'h00 : (lv_src ? lv_vec : src_vec); // R2 R6 R7

  // Sources are sampled only at reset entry; a source that is still
  // active when the pulse ends starts a fresh reset
  assign enter = in_run & any_src;
  assign leave = in_hold & (cnt_q == '0);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      RCF_RUN: begin
        if (enter) begin
          state_d = RCF_HOLD;
          cnt_d   = CW'(HOLD_CYC - 1);
        end
      end
      RCF_HOLD: begin
        if (leave) begin
          state_d = RCF_RUN;
        end else begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        state_d = RCF_HOLD;
        cnt_d   = CW'(HOLD_CYC - 1);
      end
    endcase
  end

  // Power-on leaves the block in a reset pulse with the power-on pattern
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q       <= RCF_HOLD;
      cnt_q         <= CW'(HOLD_CYC - 1);
      sys_reset_q   <= 1'b1;
      reset_cause_q <= RCF_POR_VALUE; // R5
      bus_rdata_q   <= 8'h00;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      sys_reset_q <= (state_d == RCF_HOLD); // R15
      bus_rdata_q <= rdata_d;
      if (enter) begin
        reset_cause_q <= cause_d; // R1 R7
      end
    end
  end

  // Checks

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (rst);

  logic boot_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      boot_q <= 1'b1;
    end else if (enter) begin
      boot_q <= 1'b0;
    end
  end

  // Tracks whether the latest status write carried the first key
  logic last_first_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      last_first_q <= 1'b0;
    end else if (in_hold) begin
      last_first_q <= 1'b0;
    end else if (st_wr) begin
      last_first_q <= (bus_wdata == RCF_SVC_FIRST);
    end
  end

  sequence s_svc_key1;
    in_run && st_wr && !watchdog_window_mode && bus_wdata == RCF_SVC_FIRST;
  endsequence

  sequence s_svc_key2;
    in_run && !any_src && st_wr && !watchdog_window_mode && bus_wdata == RCF_SVC_SECOND;
  endsequence

  // Idle cycles between the keys are legal; one idle cycle is covered here
  sequence s_svc_pair;
    (s_svc_key1 ##1 s_svc_key2) or (s_svc_key1 ##1 !st_wr ##1 s_svc_key2);
  endsequence

  sequence s_bad_write;
    in_run && !any_src && st_wr && watchdog_enable
    && bus_wdata != RCF_SVC_FIRST && bus_wdata != RCF_SVC_SECOND
    ##1 !(force_src || lv_src);
  endsequence

  sequence s_early_write;
    in_run && !any_src && st_wr && watchdog_enable
    && watchdog_window_mode && !watchdog_window_open
    ##1 !(force_src || lv_src);
  endsequence

  sequence s_pulse;
    sys_reset_q [*8] ##1 !sys_reset_q;
  endsequence

  flags_steady_a : assert property ( // R1
    in_run && !any_src |=> $stable(reset_cause_q)
  ) else $error("cause flags changed without a reset");

  force_clean_a : assert property ( // R2
    in_run && force_src |=> reset_cause_q == 8'h00 && sys_reset_q
  ) else $error("debug force left a flag set");

  bad_write_a : assert property ( // R3
    s_bad_write |-> ##1 sys_reset_q && reset_cause_q[RCF_B_WD]
  ) else $error("bad key write did not trip the watchdog");

  service_a : assert property ( // R4
    s_svc_pair |=> watchdog_clear_q && !sys_reset_q
  ) else $error("service pair did not clear the watchdog");

  odd_order_a : assert property ( // R17
    in_run && st_wr && bus_wdata == RCF_SVC_SECOND && !last_first_q
    |=> !watchdog_clear_q
  ) else $error("lone second key counted as service");

  boot_value_a : assert property ( // R5
    boot_q |-> reset_cause_q == RCF_POR_VALUE
  ) else $error("power-on pattern wrong");

  lv_keep_a : assert property ( // R6
    in_run && lv_src && !force_src
    |=> reset_cause_q[RCF_B_LV] && reset_cause_q[RCF_B_POR] == $past(reset_cause_q[RCF_B_POR])
        && reset_cause_q[6:2] == 5'b00000 && !reset_cause_q[RCF_B_FORCE]
  ) else $error("low-voltage pattern wrong");

  other_flags_a : assert property ( // R7
    in_run && any_src && !lv_src && !force_src
    |=> reset_cause_q == {1'b0, $past(pin_src), $past(wd_src), $past(illegal_opcode_flag_src),
                          $past(illegal_access), $past(clock_lost), 2'b00}
  ) else $error("cause pattern does not match sources");

  pin_flag_a : assert property ( // R8
    in_run && !pin_reset_n && !lv_src && !force_src |=> reset_cause_q[RCF_B_PIN] && sys_reset_q
  ) else $error("pin reset not recorded");

  wd_block_a : assert property ( // R9
    in_run && any_src && !watchdog_enable |=> !reset_cause_q[RCF_B_WD]
  ) else $error("disabled watchdog recorded a reset");

  stop_bar_a : assert property ( // R10
    in_run && stop_exec && !stop_allowed && !lv_src && !force_src |=> reset_cause_q[RCF_B_ILLEGAL_OPCODE_FLAG]
  ) else $error("barred stop not seen as illegal opcode");

  addr_flag_a : assert property ( // R11
    in_run && illegal_access && !lv_src && !force_src |=> reset_cause_q[RCF_B_ILLEGAL_ADDRESS_FLAG]
  ) else $error("illegal address not recorded");

  clock_flag_a : assert property ( // R12
    in_run && clock_lost && !lv_src && !force_src |=> reset_cause_q[RCF_B_LOC]
  ) else $error("clock loss not recorded");

  user_force_a : assert property ( // R13
    in_run && bus_wr && hit_force && !bus_bdm && !any_src |=> !sys_reset_q
  ) else $error("user write to force register acted");

  force_read_a : assert property ( // R14
    bus_rd && hit_force |=> bus_rdata_q == 8'h00
  ) else $error("force register read nonzero");

  force_pulse_a : assert property ( // R15
    in_run && force_src |=> s_pulse
  ) else $error("forced reset pulse has wrong length");

  early_write_a : assert property ( // R16
    s_early_write |-> ##1 sys_reset_q && reset_cause_q[RCF_B_WD]
  ) else $error("early window write did not reset");

  timeout_flag_a : assert property ( // R9
    in_run && watchdog_enable && watchdog_timeout && !lv_src && !force_src
    |=> reset_cause_q[RCF_B_WD] && sys_reset_q
  ) else $error("watchdog timeout not recorded");

  bg_bar_a : assert property ( // R10
    in_run && background_entry_opcode && !background_mode_allowed && !lv_src && !force_src
    |=> reset_cause_q[RCF_B_ILLEGAL_OPCODE_FLAG]
  ) else $error("barred background entry not seen as illegal opcode");

  unimpl_flag_a : assert property ( // R10
    in_run && opcode_unimpl && !lv_src && !force_src |=> reset_cause_q[RCF_B_ILLEGAL_OPCODE_FLAG]
  ) else $error("unimplemented opcode not recorded");

  status_read_a : assert property ( // R1
    bus_rd && hit_st |=> bus_rdata_q == $past(reset_cause_q)
  ) else $error("status read returned wrong flags");

  zero_bit_a : assert property ( // R1
    !reset_cause_q[RCF_B_FORCE]
  ) else $error("unused status bit set");

  entry_pulse_a : assert property ( // R7
    in_run && any_src |=> sys_reset_q
  ) else $error("active source did not start a reset");

  hold_steady_a : assert property ( // R7
    in_hold |=> $stable(reset_cause_q)
  ) else $error("cause flags changed inside a reset pulse");

  clear_pulse_a : assert property ( // R4
    watchdog_clear_q |=> !watchdog_clear_q
  ) else $error("watchdog clear longer than one cycle");

endmodule

/* hw/rcf_svc_seq.sv */
module rcf_svc_seq
  import rcf_pkg::*;
(
  // Clock and reset
  input  logic       sys_clk,
  input  logic       rst,
  // Write watch
  input  logic       clear,
  input  logic       wr,
  input  logic [7:0] wdata,
  input  logic       window_mode,
  input  logic       window_open,
  // Results
  output logic       service_q,
  output logic       bad_q
);

  logic is_first;
  logic is_second;
  logic early;
  logic bad_d;
  logic service_d;
  logic armed_q;
  logic armed_d;

  assign is_first  = (wdata == RCF_SVC_FIRST);
  assign is_second = (wdata == RCF_SVC_SECOND);
  // Window closed: every write counts as misuse
  assign early     = window_mode & ~window_open; // R16

  assign bad_d     = ~clear & wr & (early | ~(is_first | is_second)); // R3

  // Only the very next write after the first key may complete a service
  assign service_d = ~clear & wr & ~early & is_second & armed_q; // R17
  assign armed_d   = clear ? 1'b0 : (wr ? (is_first & ~early) : armed_q); // R17

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      armed_q   <= 1'b0;
      service_q <= 1'b0;
      bad_q     <= 1'b0;
    end else begin
      armed_q   <= armed_d;
      service_q <= service_d; // R4
      bad_q     <= bad_d;
    end
  end

endmodule

/* testbench/rcf_host.sv */
module rcf_host
  import rcf_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // CPU bus and serial debug writes
  output logic [RCF_AW-1:0]      bus_addr,
  output logic                   bus_wr,
  output logic                   bus_rd,
  output logic                   bus_bdm,
  output logic [7:0]             bus_wdata,
  input  wire logic [7:0]        bus_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bus_addr  = '0;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_bdm   = 1'b0;
    bus_wdata = '0;
  end

  // One-cycle strobe; released lines flip so no stale value looks valid
  task automatic write(input logic [15:0] a, input logic [7:0] d, input logic bdm);
    @(negedge sys_clk);
    bus_addr  = a;
    bus_wdata = d;
    bus_bdm   = bdm;
    bus_wr    = 1'b1;
    @(negedge sys_clk);
    bus_wr    = 1'b0;
    bus_bdm   = 1'b0;
    bus_wdata = ~d;
    bus_addr  = ~a;
  endtask

  task automatic read(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    bus_addr = a;
    bus_rd   = 1'b1;
    @(negedge sys_clk);
    bus_rd   = 1'b0;
    bus_addr = ~a;
    d        = bus_rdata_q;
  endtask
endmodule

/* testbench/testbench.sv */
module testbench
  import rcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              sys_clk;
  logic              rst;
  logic              sys_reset_q;
  logic              watchdog_clear_q;
  logic              bus_wr;
  logic              bus_rd;
  logic              bus_bdm;
  logic [RCF_AW-1:0] bus_addr;
  logic [7:0]        bus_wdata;
  logic [7:0]        bus_rdata_q;
  logic [7:0]        reset_cause_q;
  logic [7:0]        rd;
  // Config: wd enable, window mode, window open, lv reset enable, stop allowed, bg allowed
  logic [5:0]        cfg;
  // Sources: pin, timeout, lv, unimpl, stop, bg, illegal access, clock lost
  logic [7:0]        src;
  int                fail_count;
  int                num_checks;
  int                n;

  rcf_reset_cause #(.HOLD_CYC(8)) rcf_reset_cause_inst (
    .sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_bdm(bus_bdm), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
    .watchdog_enable(cfg[0]), .watchdog_window_mode(cfg[1]), .watchdog_window_open(cfg[2]),
    .low_voltage_reset_enable(cfg[3]), .stop_allowed(cfg[4]), .background_mode_allowed(cfg[5]),
    .pin_reset_n(~src[0]), .watchdog_timeout(src[1]), .lv_below_trip(src[2]), .opcode_unimpl(src[3]),
    .stop_exec(src[4]), .background_entry_opcode(src[5]), .illegal_access(src[6]),
    .clock_lost(src[7]), .sys_reset_q(sys_reset_q), .watchdog_clear_q(watchdog_clear_q),
    .reset_cause_q(reset_cause_q));

  rcf_host rcf_host_inst (
    .sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_bdm(bus_bdm), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("TB: checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Reset entry within 3 cycles, cause pattern, then pulse width in cycles
  task automatic pulse(input logic [7:0] exp);
    int k;
    k = 0;
    while (sys_reset_q !== 1'b1 && k < 4) begin
      @(negedge sys_clk);
      k++;
    end
    src = '0;
    if (k == 4) begin
      fail_count++;
      wrap_up();
    end
    check(reset_cause_q, exp);
    k = 0;
    while (sys_reset_q === 1'b1 && k < 20) begin
      k++;
      @(negedge sys_clk);
    end
    check(8'(k), 8'h08);
  endtask

  task automatic quiet();
    int k;
    k = 0;
    repeat (6) begin
      @(negedge sys_clk);
      if (sys_reset_q !== 1'b0) k++;
    end
    src = '0;
    check(8'(k), 8'h00);
  endtask

  // e[8] set means a reset is expected with cause e[7:0]
  task automatic run_case(input logic [5:0] c, input logic [7:0] s, input logic [8:0] e);
    @(negedge sys_clk);
    cfg = c;
    src = s;
    if (e[8]) pulse(e[7:0]);
    else quiet();
  endtask

  task automatic clears(input logic [7:0] exp);
    int k;
    k = 0;
    repeat (4) begin
      if (watchdog_clear_q === 1'b1) k++;
      @(negedge sys_clk);
    end
    check(8'(k), exp);
  endtask

  initial begin
    rst = 1'b1;
    cfg = '0;
    src = '0;
    fail_count = 0;
    num_checks = 0;
    repeat (4) @(negedge sys_clk);
    check(reset_cause_q, 8'h82);
    rst = 1'b0;
    n = 0;
    while (sys_reset_q !== 1'b0 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 20) fail_count++;
    rcf_host_inst.read(RCF_STATUS_ADDR, rd);
    check(rd, 8'h82);
    rcf_host_inst.read(RCF_FORCE_ADDR, rd);
    check(rd, 8'h00);
    run_case(6'b001000, 8'h04, 9'h182);
    run_case(6'b001000, 8'h04, 9'h182);
    run_case(6'b000000, 8'h04, 9'h000);
    run_case(6'b000000, 8'h01, 9'h140);
    run_case(6'b000001, 8'h02, 9'h120);
    run_case(6'b000000, 8'h02, 9'h000);
    run_case(6'b000000, 8'h08, 9'h110);
    run_case(6'b000000, 8'h10, 9'h110);
    run_case(6'b010000, 8'h10, 9'h000);
    run_case(6'b000000, 8'h20, 9'h110);
    run_case(6'b100000, 8'h20, 9'h000);
    run_case(6'b000000, 8'h40, 9'h108);
    run_case(6'b000000, 8'h80, 9'h104);
    run_case(6'b000001, 8'hC3, 9'h16C);
    run_case(6'b001000, 8'h05, 9'h102);
    cfg = 6'b000001;
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'h55, 1'b0);
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'hAA, 1'b0);
    clears(8'h01);
    rcf_host_inst.read(RCF_STATUS_ADDR, rd);
    check(rd, 8'h02);
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'hAA, 1'b0);
    clears(8'h00);
    quiet();
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'h55, 1'b0);
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'h55, 1'b0);
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'hAA, 1'b0);
    clears(8'h01);
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'h55, 1'b0);
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'h12, 1'b0);
    pulse(8'h20);
    cfg = 6'b000000;
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'h12, 1'b0);
    quiet();
    cfg = 6'b000011;
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'h55, 1'b0);
    pulse(8'h20);
    cfg = 6'b000111;
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'h55, 1'b0);
    rcf_host_inst.write(RCF_STATUS_ADDR, 8'hAA, 1'b0);
    clears(8'h01);
    cfg = 6'b000000;
    rcf_host_inst.write(RCF_FORCE_ADDR, 8'h01, 1'b0);
    quiet();
    rcf_host_inst.write(RCF_FORCE_ADDR, 8'hFE, 1'b1);
    quiet();
    rcf_host_inst.write(RCF_FORCE_ADDR, 8'h01, 1'b1);
    pulse(8'h00);
    rcf_host_inst.read(RCF_FORCE_ADDR, rd);
    check(rd, 8'h00);
    wrap_up();
  end
endmodule
